/* rtl/asp_pkg.sv */
// Purpose: Shared constants and types of the converter serial port sequencer.
// Assumes: 32-bit AXI4-Lite register bus, 12-bit result.
// Notes:   Every offset and count used by the logic lives here; the STATUS and RESULT field positions do not.
package asp_pkg;

	// ****************************************************************
	// Result and sequence counts
	// ****************************************************************
	localparam int         RES_W            = 12;
	localparam int         CFG_W            = 3;
	localparam logic [1:0] CFG_LAST         = 2'h2;
	localparam logic [3:0] NULL_FALL_SINGLE = 4'h2;
	localparam logic [3:0] NULL_FALL_DUAL   = 4'h4;
	localparam logic [3:0] MSB_IDX          = 4'hB;
	localparam logic [3:0] LSB_COPY_START   = 4'h1;
	localparam logic [3:0] LSB_IDX          = 4'h0;
	localparam int         CFG_SGL          = 2;
	localparam int         CFG_POL          = 1;
	localparam int         CFG_ORD          = 0;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int          ADDR_W       = 4;
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_STATUS   = 4'h4;
	localparam logic [3:0]  REG_RESULT   = 4'h8;
	localparam int          CTRL_EN_BIT  = 0;
	localparam logic        CTRL_EN_RST  = 1'b1;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

	// ****************************************************************
	// Sequencer states, Gray coded along the usual path
	// ****************************************************************
	typedef enum logic [2:0] {
		ASP_IDLE    = 3'h0,
		ASP_HUNT    = 3'h1,
		ASP_CONFIG  = 3'h3,
		ASP_ACQUIRE = 3'h2,
		ASP_MSB     = 3'h6,
		ASP_LSB     = 3'h7,
		ASP_ZERO    = 3'h5
	} asp_state_t;

endpackage : asp_pkg

/* rtl/asp_pin_sync.sv */
// Purpose: Two-stage synchroniser with edge detection for link pins.
// Assumes: Pins are asynchronous to clk and slow compared with it.
// Notes:   Edges come from the second and third stages only.
`timescale 1ns/1ps
`default_nettype none
module asp_pin_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Raw pins
	input  wire logic [W-1:0] pin_in,
	// Synchronised level and edge pulses
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] prev_ff;

	// The first stage feeds only the second, to let metastability settle.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// Edge pulses last one clk cycle.
	assign level = sync_ff;
	assign rise  = sync_ff & ~prev_ff;
	assign fall  = ~sync_ff & prev_ff;

endmodule : asp_pin_sync
`default_nettype wire

/* rtl/asp_serial_port_sequencer.sv */
// Purpose: Serial port and conversion sequencer of a 12-bit sampling converter.
// Assumes: Shift clock far slower than clk; analog codes held steady while sampled.
// Notes:   DUAL_CHANNEL selects the two-channel variant with a serial input.
// Operation
// - Bits leave on shift clock falling edges and are sampled on rising edges.
// - Conversion steps advance only on shift clock edges from the host.
// - Single-input variant starts on chip select falling; serial input is unused.
// - Single-input variant enables the output on the second falling clock.
// - Exactly one null bit precedes the result once the output is enabled.
// - The result is twelve bits, delivered serially.
// - Single-input sends MSB first then LSB first sharing bit zero, then zeros.
// - Chip select high aborts any exchange and returns everything to idle.
// - Chip select low means active while the port is enabled; high means disabled and powered down.
// - Two-channel variant ignores zeros; first sampled one is the start bit.
// - Three configuration bits follow the start bit and start the conversion.
// - After the configuration, serial input is ignored until chip select cycles.
// - Config picks input a, input b, a minus b or b minus a.
// - Two-channel variant receives first, then transmits: half duplex.
// - After all result bits, zeros are sent while clocks continue.
// - Comparator and bias power down at end of conversion; shifting continues.
// - Sampling spans one and a half clocks, conversion twelve clocks.
// - Bit order one gives MSB first then zeros; zero adds LSB copy.
// - Shared line is driven low on the fourth falling edge after start.
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_sequencer #(
	parameter bit DUAL_CHANNEL = 1'b1
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Serial link pins
	input  wire logic        chip_select_n,
	input  wire logic        shift_clock,
	input  wire logic        serial_in_line,
	output logic             serial_out_o,
	output logic             serial_out_oe,
	// Digitised stand-ins of the analog inputs
	input  wire logic [11:0] analog_input_a,
	input  wire logic [11:0] analog_input_b,
	// Power state
	output logic             device_active,
	output logic             comparator_powered,
	// AXI4-Lite write channels
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	logic [2:0] pin_lvl;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;
	logic [11:0] a_meta_ff, a_sync_ff, b_meta_ff, b_sync_ff;

	// Chip select enters inverted so the cleared stages read as deselected after reset.
	// Otherwise the port would look selected and active for two cycles after reset.
	asp_pin_sync #(.W(3)) u_sync (
		.clk    (clk),
		.rst_n  (rst_n),
		.pin_in ({~chip_select_n, shift_clock, serial_in_line}),
		.level  (pin_lvl),
		.rise   (pin_rise),
		.fall   (pin_fall)
	);

	// Analog stand-ins also pass two stages before use.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			a_meta_ff <= '0;
			a_sync_ff <= '0;
			b_meta_ff <= '0;
			b_sync_ff <= '0;
		end else begin
			a_meta_ff <= analog_input_a;
			a_sync_ff <= a_meta_ff;
			b_meta_ff <= analog_input_b;
			b_sync_ff <= b_meta_ff;
		end
	end

	logic cs_hi, cs_fall, sclk_rise, sclk_fall, din;
	logic port_en_ff;
	logic quiet;
	assign cs_hi     = ~pin_lvl[2];
	assign cs_fall   = pin_rise[2];
	assign sclk_rise = pin_rise[1];
	assign sclk_fall = pin_fall[1];
	// Single-input variant has no serial input path at all.
	// input path absent
	assign din       = DUAL_CHANNEL ? pin_lvl[0] : 1'b0;
	// Chip select high, or the port switched off, holds everything idle.
	assign quiet     = cs_hi | ~port_en_ff;

	// ****************************************************************
	// Result computation
	// ****************************************************************
	// Unipolar only: a negative difference clips to zero.
	function automatic logic [11:0] asp_convert(input logic sgl, input logic pol,
	                                            input logic [11:0] a, input logic [11:0] b);
		logic [11:0] res;
		res = '0;
		if (sgl)
			res = pol ? b : a;
		else if (!pol)
			res = (a >= b) ? 12'(a - b) : 12'h000;
		else
			res = (b >= a) ? 12'(b - a) : 12'h000;
		return res;
	endfunction : asp_convert

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	asp_pkg::asp_state_t state_ff;
	logic [3:0]  fcnt_ff;
	logic [3:0]  bit_idx_ff;
	logic [1:0]  cfg_cnt_ff;
	logic [2:0]  cfg_ff;
	logic [11:0] code_ff;
	logic [3:0]  null_fall;
	logic        null_evt;
	logic        lsb_copy;

	assign null_fall = DUAL_CHANNEL ? asp_pkg::NULL_FALL_DUAL : asp_pkg::NULL_FALL_SINGLE;
	assign null_evt  = !quiet && sclk_fall && state_ff == asp_pkg::ASP_ACQUIRE
	                   && 4'(fcnt_ff + 4'h1) == null_fall;
	assign lsb_copy  = DUAL_CHANNEL ? !cfg_ff[asp_pkg::CFG_ORD] : 1'b1;

	// Main state walk; leaving idle waits for chip select, every later step for a shift clock edge.
	// clock-paced steps
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff   <= asp_pkg::ASP_IDLE;
			bit_idx_ff <= '0;
		end else if (quiet) begin
			state_ff   <= asp_pkg::ASP_IDLE;
		end else begin
			case (state_ff)
				asp_pkg::ASP_IDLE: begin
					if (cs_fall)
						state_ff <= DUAL_CHANNEL ? asp_pkg::ASP_HUNT : asp_pkg::ASP_ACQUIRE;
				end
				asp_pkg::ASP_HUNT: begin
					if (sclk_rise && din)
						state_ff <= asp_pkg::ASP_CONFIG;
				end
				asp_pkg::ASP_CONFIG: begin
					if (sclk_rise && cfg_cnt_ff == asp_pkg::CFG_LAST)
						state_ff <= asp_pkg::ASP_ACQUIRE;
				end
				asp_pkg::ASP_ACQUIRE: begin
					if (null_evt) begin
						state_ff   <= asp_pkg::ASP_MSB;
						bit_idx_ff <= asp_pkg::MSB_IDX;
					end
				end
				asp_pkg::ASP_MSB: begin
					if (sclk_fall) begin
						if (bit_idx_ff == asp_pkg::LSB_IDX) begin
							state_ff   <= lsb_copy ? asp_pkg::ASP_LSB : asp_pkg::ASP_ZERO;
							bit_idx_ff <= asp_pkg::LSB_COPY_START;
						end else begin
							bit_idx_ff <= 4'(bit_idx_ff - 4'h1);
						end
					end
				end
				asp_pkg::ASP_LSB: begin
					if (sclk_fall) begin
						if (bit_idx_ff == asp_pkg::MSB_IDX)
							state_ff <= asp_pkg::ASP_ZERO;
						else
							bit_idx_ff <= 4'(bit_idx_ff + 4'h1);
					end
				end
				asp_pkg::ASP_ZERO: state_ff <= asp_pkg::ASP_ZERO;
				default:           state_ff <= asp_pkg::ASP_IDLE;
			endcase
		end
	end

	// Falling edges counted from the arming point; only the null edge reads it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			fcnt_ff <= '0;
		else if (state_ff == asp_pkg::ASP_IDLE || state_ff == asp_pkg::ASP_HUNT)
			fcnt_ff <= '0;
		else if (sclk_fall && (state_ff == asp_pkg::ASP_CONFIG
		                       || state_ff == asp_pkg::ASP_ACQUIRE))
			fcnt_ff <= 4'(fcnt_ff + 4'h1);
	end

	// Config bits are taken on rising edges, first bit ending in the top slot.
	// cfg_ff is kept after the frame so software can still read it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_ff     <= '0;
			cfg_cnt_ff <= '0;
		end else if (state_ff == asp_pkg::ASP_HUNT) begin
			cfg_cnt_ff <= '0;
		end else if (!quiet && sclk_rise && state_ff == asp_pkg::ASP_CONFIG) begin
			// sample on rise, config phase only
			cfg_ff     <= {cfg_ff[1:0], din};
			cfg_cnt_ff <= 2'(cfg_cnt_ff + 2'h1);
		end
	end

	// The held code is taken at the end of the sampling window.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			code_ff <= '0;
		else if (null_evt)
			code_ff <= asp_convert(DUAL_CHANNEL ? cfg_ff[asp_pkg::CFG_SGL] : 1'b0,
			                       DUAL_CHANNEL ? cfg_ff[asp_pkg::CFG_POL] : 1'b0,
			                       a_sync_ff, b_sync_ff);
	end

	// Output pin; the enable only rises after the whole config is in.
	// half duplex turn
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_out_o  <= 1'b0;
			serial_out_oe <= 1'b0;
		end else if (quiet) begin
			serial_out_o  <= 1'b0;
			serial_out_oe <= 1'b0;
		end else if (null_evt) begin
			serial_out_o  <= 1'b0;
			serial_out_oe <= 1'b1;
		end else if (sclk_fall) begin
			case (state_ff)
				asp_pkg::ASP_MSB: serial_out_o <= code_ff[bit_idx_ff];
				asp_pkg::ASP_LSB: serial_out_o <= code_ff[bit_idx_ff];
				asp_pkg::ASP_ZERO: serial_out_o <= 1'b0;
				default:          serial_out_o <= serial_out_o;
			endcase
		end
	end

	// Power state follows the sequencer one cycle late, which is harmless.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			device_active      <= 1'b0;
			comparator_powered <= 1'b0;
		end else begin
			device_active      <= !quiet;
			comparator_powered <= !quiet && (state_ff == asp_pkg::ASP_CONFIG
			                      || state_ff == asp_pkg::ASP_ACQUIRE
			                      || state_ff == asp_pkg::ASP_MSB);
		end
	end

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	logic        aw_got_ff, w_got_ff, do_write;
	logic [3:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;

	// Address and data are taken independently and joined here.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_got_ff     <= 1'b0;
			s_axi_awready <= 1'b0;
			awaddr_ff     <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_ff     <= 1'b1;
			s_axi_awready <= 1'b0;
			awaddr_ff     <= s_axi_awaddr;
		end else if (do_write) begin
			aw_got_ff     <= 1'b0;
		end else if (!aw_got_ff && !s_axi_bvalid) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w_got_ff     <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_ff     <= '0;
			wstrb_ff     <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_ff     <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_ff     <= s_axi_wdata;
			wstrb_ff     <= s_axi_wstrb;
		end else if (do_write) begin
			w_got_ff     <= 1'b0;
		end else if (!w_got_ff && !s_axi_bvalid) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Write response and the control register; unmapped writes get SLVERR.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= asp_pkg::RESP_OKAY;
			port_en_ff   <= asp_pkg::CTRL_EN_RST;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_ff == asp_pkg::REG_CTRL || awaddr_ff == asp_pkg::REG_STATUS
			                 || awaddr_ff == asp_pkg::REG_RESULT)
			                ? asp_pkg::RESP_OKAY : asp_pkg::RESP_SLVERR;
			if (awaddr_ff == asp_pkg::REG_CTRL && wstrb_ff[0])
				port_en_ff <= wdata_ff[asp_pkg::CTRL_EN_BIT];
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Reads answer one cycle after the address is taken.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= asp_pkg::WORD_ZERO;
			s_axi_rresp   <= asp_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= asp_pkg::RESP_OKAY;
			case (s_axi_araddr)
				asp_pkg::REG_CTRL:   s_axi_rdata <= {31'h0, port_en_ff};
				asp_pkg::REG_STATUS: s_axi_rdata <= {27'h0, state_ff, comparator_powered,
				                                     device_active};
				asp_pkg::REG_RESULT: s_axi_rdata <= {17'h0, cfg_ff, code_ff};
				default: begin
					s_axi_rdata <= asp_pkg::WORD_ZERO;
					s_axi_rresp <= asp_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_cs_hiz;
		cs_hi |=> !serial_out_oe;
	endproperty
	a_cs_hiz: assert property (p_cs_hiz) else $error("output driven while deselected");

	property p_abort;
		cs_hi |=> state_ff == asp_pkg::ASP_IDLE;
	endproperty
	a_abort: assert property (p_abort) else $error("select high did not reset");

	property p_null_zero;
		$rose(serial_out_oe) |-> !serial_out_o && state_ff == asp_pkg::ASP_MSB
		                         && bit_idx_ff == asp_pkg::MSB_IDX;
	endproperty
	a_null_zero: assert property (p_null_zero) else $error("null bit wrong");

	property p_enable_edge;
		$rose(serial_out_oe) |-> fcnt_ff == null_fall && $past(sclk_fall);
	endproperty
	a_enable_edge: assert property (p_enable_edge) else $error("enable on wrong edge");

	property p_lsb_turn;
		$past(state_ff) == asp_pkg::ASP_MSB && state_ff == asp_pkg::ASP_LSB
		|-> bit_idx_ff == asp_pkg::LSB_COPY_START && serial_out_o == code_ff[0];
	endproperty
	a_lsb_turn: assert property (p_lsb_turn) else $error("LSB copy start wrong");

	property p_zeros;
		state_ff == asp_pkg::ASP_ZERO && sclk_fall && !quiet |=> !serial_out_o;
	endproperty
	a_zeros: assert property (p_zeros) else $error("nonzero after result");

	property p_cfg_frozen;
		state_ff inside {asp_pkg::ASP_MSB, asp_pkg::ASP_LSB, asp_pkg::ASP_ZERO}
		|=> $stable(cfg_ff);
	endproperty
	a_cfg_frozen: assert property (p_cfg_frozen) else $error("config changed late");

	property p_hunt_zero;
		state_ff == asp_pkg::ASP_HUNT && sclk_rise && !din && !quiet
		|=> state_ff == asp_pkg::ASP_HUNT;
	endproperty
	a_hunt_zero: assert property (p_hunt_zero) else $error("zero taken as start");

	property p_power_down;
		state_ff inside {asp_pkg::ASP_LSB, asp_pkg::ASP_ZERO} |=> !comparator_powered;
	endproperty
	a_power_down: assert property (p_power_down) else $error("comparator still on");

	property p_clock_paced;
		!sclk_fall && !sclk_rise && !quiet && state_ff != asp_pkg::ASP_IDLE
		|=> $stable(state_ff) && $stable(bit_idx_ff);
	endproperty
	a_clock_paced: assert property (p_clock_paced) else $error("step without clock");

	property p_active;
		!quiet ##1 !quiet |-> device_active;
	endproperty
	a_active: assert property (p_active) else $error("not active while selected");

endmodule : asp_serial_port_sequencer
`default_nettype wire

/* sim/asp_host_model.sv */
// Purpose: Behavioural host that drives chip select, shift clock and the data wire.
// Assumes: Shift clock of 80 ns that idles low, halves of four clk cycles.
// Notes:   Data input and serial output share one wire, resolved here.
`timescale 1ns/1ps
`default_nettype none
module asp_host_model (
	// Clock
	input  wire logic clk,
	// Device side of the shared wire
	input  wire logic dev_out,
	input  wire logic dev_oe,
	// Host pins
	output var logic  chip_select_n,
	output var logic  shift_clock,
	output logic      data_line
);
	// ****************************************************************
	// Shared wire
	// ****************************************************************
	logic drv_en, drv_val, last_ff;
	logic got[$];
	int   oe_seen;

	initial begin
		chip_select_n = 1'b1;
		shift_clock   = 1'b0;
		drv_en        = 1'b0;
		drv_val       = 1'b0;
		last_ff       = 1'b0;
		oe_seen       = 0;
	end

	// A released wire shows the inverse of its last level, so stale data never matches.
	// one half duplex wire
	always_comb data_line = (dev_oe & drv_en) ? 1'bx :
		dev_oe ? dev_out : (drv_en ? drv_val : ~last_ff);

	// Remember the last driven level and count cycles with the device driving.
	always @(posedge clk) begin
		if (dev_oe | drv_en) last_ff <= data_line;
		if (dev_oe) oe_seen <= oe_seen + 1;
	end

	// change on fall, sample on rise
	task automatic tick(input logic en, input logic v, input logic hold);
		shift_clock <= 1'b0;
		drv_en      <= en;
		drv_val     <= v;
		repeat (4) @(posedge clk);
		shift_clock <= 1'b1;
		got.push_back(dev_oe ? data_line : 1'bz); // Released line kept as z, so enable shows.
		repeat (2) @(posedge clk);
		drv_en <= hold;
		repeat (2) @(posedge clk);
	endtask : tick

	// zeros, start bit, then sgl, pol, order
	task automatic frame(input logic [2:0] cfg, input int nz, input int nrx);
		chip_select_n <= 1'b0;
		repeat (4) @(posedge clk);
		repeat (nz) tick(1'b1, 1'b0, 1'b1);
		tick(1'b1, 1'b1, 1'b1);
		tick(1'b1, cfg[2], 1'b1);
		tick(1'b1, cfg[1], 1'b1);
		tick(1'b1, cfg[0], 1'b0);
		got.delete();
		repeat (nrx) tick(1'b0, 1'b0, 1'b0);
		shift_clock <= 1'b0;
		repeat (4) @(posedge clk);
		chip_select_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : frame

	// Single-input frame: no data word, every rise from the first pulse is recorded.
	task automatic sframe(input int nrx);
		chip_select_n <= 1'b0;
		repeat (4) @(posedge clk);
		got.delete();
		repeat (nrx) tick(1'b0, 1'b0, 1'b0);
		shift_clock <= 1'b0;
		repeat (4) @(posedge clk);
		chip_select_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : sframe
endmodule : asp_host_model
`default_nettype wire

/* sim/testbench.sv */
// Purpose: Self-checking bench of the converter serial port sequencer.
// Assumes: Both variants, 100 MHz clk, 80 ns shift clock.
// Notes:   Expected serial bits and codes come from a model in this file.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic        clk, rst_n, cs_n, sclk, line, dout, doe, dev_act, cmp_pwr;
	logic        cs_s, sclk_s, line_s, dout_s, doe_s, act_s;
	logic [11:0] ana_a, ana_b;
	logic [3:0]  awaddr, araddr, wstrb;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	int          failures, num_checks, o0;

	asp_serial_port_sequencer #(.DUAL_CHANNEL(1'b1)) dut (
		.clk(clk), .rst_n(rst_n), .chip_select_n(cs_n), .shift_clock(sclk),
		.serial_in_line(line), .serial_out_o(dout), .serial_out_oe(doe),
		.analog_input_a(ana_a), .analog_input_b(ana_b),
		.device_active(dev_act), .comparator_powered(cmp_pwr),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	asp_host_model host (.clk(clk), .dev_out(dout), .dev_oe(doe),
		.chip_select_n(cs_n), .shift_clock(sclk), .data_line(line));

	// Single-input variant on its own host; it follows the bus inputs, its answers unused.
	asp_serial_port_sequencer #(.DUAL_CHANNEL(1'b0)) dut_s (
		.clk(clk), .rst_n(rst_n), .chip_select_n(cs_s), .shift_clock(sclk_s),
		.serial_in_line(line_s), .serial_out_o(dout_s), .serial_out_oe(doe_s),
		.analog_input_a(ana_a), .analog_input_b(ana_b),
		.device_active(act_s), .comparator_powered(),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
		.s_axi_rvalid(), .s_axi_rready(rready));

	asp_host_model host_s (.clk(clk), .dev_out(dout_s), .dev_oe(doe_s),
		.chip_select_n(cs_s), .shift_clock(sclk_s), .data_line(line_s));

	// Free running system clock.
	always #5 clk = ~clk;

	// ****************************************************************
	// Tasks and model
	// ****************************************************************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic finish_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	// Write: address and data offered together, each dropped once taken.
	task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : axr

	// Null bit, MSB first, optional LSB-first copy sharing bit zero, then zeros.
	function automatic logic exp_bit(input logic [2:0] cfg, input int code, input int i);
		if (i >= 1 && i <= 12) return code[12-i];
		if (!cfg[0] && i >= 13 && i <= 23) return code[i-12];
		return 1'b0;
	endfunction : exp_bit

	// One frame with random codes; every received bit compared with the model.
	task automatic run(input logic [2:0] cfg, input int nz, input int nrx);
		int ia, ib, code;
		ia = $urandom % 4096;
		ib = $urandom % 4096;
		ana_a <= 12'(ia);
		ana_b <= 12'(ib);
		code = cfg[2] ? (cfg[1] ? ib : ia) : (cfg[1] ? ib - ia : ia - ib);
		if (code < 0) code = 0;
		@(posedge clk);
		host.frame(cfg, nz, nrx);
		chk(32'(host.got.size()), 32'(nrx));
		foreach (host.got[i]) chk({31'h0, host.got[i]}, {31'h0, exp_bit(cfg, code, i)});
		chk({29'h0, doe, dev_act, cmp_pwr}, 32'h0);
		axr(asp_pkg::REG_RESULT, d, r);
		chk(d, {17'h0, cfg, 12'(code)});
	endtask : run

	// Single-input frame: two released pulses, the null bit, then the a minus b stream.
	task automatic srun(input int nrx);
		int ia, ib, code;
		ia = $urandom % 4096;
		ib = $urandom % 4096;
		ana_a <= 12'(ia);
		ana_b <= 12'(ib);
		code = (ia >= ib) ? ia - ib : 0;
		@(posedge clk);
		host_s.sframe(nrx);
		chk(32'(host_s.got.size()), 32'(nrx));
		foreach (host_s.got[i])
			chk({31'h0, host_s.got[i]}, {31'h0, (i < 2) ? 1'bz : exp_bit(3'h0, code, i - 2)});
		chk({30'h0, doe_s, act_s}, 32'h0);
	endtask : srun

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		clk = 0; rst_n = 0; ana_a = 0; ana_b = 0; wstrb = 4'hF; wdata = 0;
		awaddr = 0; araddr = 0; awvalid = 0; wvalid = 0; bready = 0;
		arvalid = 0; rready = 0; failures = 0; num_checks = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		void'($urandom(71820));
		axr(asp_pkg::REG_CTRL, d, r);
		chk(d, 32'h1);
		axr(4'hC, d, r);
		chk({30'h0, r}, 32'h2);
		axw(4'hC, 32'hFFFF_FFFF, r);
		chk({30'h0, r}, 32'h2);
		for (int k = 0; k < 8; k++) run(3'(k), k % 3, 26);
		host.frame(3'h5, 1, 3);
		axr(asp_pkg::REG_STATUS, d, r);
		chk(d, 32'h0);
		run(3'h2, 0, 13);
		axw(asp_pkg::REG_CTRL, 32'h0, r);
		axr(asp_pkg::REG_CTRL, d, r);
		chk(d, 32'h0);
		o0 = host.oe_seen;
		host.frame(3'h4, 0, 6);
		chk(32'(host.oe_seen - o0), 32'h0);
		axw(asp_pkg::REG_CTRL, 32'h1, r);
		run(3'h4, 2, 30);
		srun(30);
		srun(15);
		finish_test();
	end

	// Cuts a hang short; the sequence needs about 3200 cycles.
	initial begin
		repeat (30000) @(posedge clk);
		failures++;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
